// *** src/mdfm_fault_mgr.sv ***
// Fault supervision and 100% duty current-limit restart for a three-phase power stage
// ==========================================================
// Overview of operation
// - Current-limit cut high side at full duty is re-enabled by internal restart clock
// - Restart clock 20 or 40 kHz by select bit; pin-configured parts fixed 20 kHz
// - Supply undervoltage: bridge Hi-Z, pump and logic off, automatic recovery
// - After undervoltage the power-on-reset status stays low until cleared
// - Regulator-supply undervoltage behaves exactly like supply undervoltage
// - Step-down undervoltage: regulator off only, fault low, three flags set
// - Step-down recovery automatic; its flags stay until cleared
// - Pump undervoltage: bridge Hi-Z, fault low, flags latched, automatic recovery
// - Pump undervoltage protection can never be disabled
// - Overvoltage when enabled: bridge Hi-Z, fault low, flag latched, auto recovery
// - Register parts: overvoltage acts only with its enable bit set
// - Pin-configured parts: overvoltage always on at the 34 V threshold
// - Register parts: threshold select bit picks 20 V or 32 V
// - Overcurrent counts only after the deglitch time, then follows mode
// - Pin-configured parts: 0.6 us deglitch, latched shutdown always
// - Register parts: level, deglitch and four response modes from register
// - Step-down overcurrent: fault low, bridge running, retry after retry time
// - Serial error reported on fault pin unless report-disable is set
// - Trim memory read error: fault low, Hi-Z, cleared only by sleep pulse
// - Retry mode keeps overcurrent flags latched until a clear
`timescale 1ns/1ps
`default_nettype none
`include "mdfm_map.svh"

module mdfm_fault_mgr
    import mdfm_pkg::*;
#(
    parameter int unsigned RETRY_CYC = `MDFM_RETRY_CYC,
    parameter int unsigned REG_RETRY_CYC = `MDFM_REG_RETRY_CYC,
    parameter int unsigned RST_MAX_CYC = `MDFM_RST_MAX_CYC
) (
    input wire logic aclk,
    input wire logic aresetn,
    input wire logic s_axi_awvalid,
    output logic s_axi_awready,
    input wire logic [7:0] s_axi_awaddr,
    input wire logic [2:0] s_axi_awprot,
    input wire logic s_axi_wvalid,
    output logic s_axi_wready,
    input wire logic [31:0] s_axi_wdata,
    input wire logic [3:0] s_axi_wstrb,
    output logic s_axi_bvalid,
    input wire logic s_axi_bready,
    output logic [1:0] s_axi_bresp,
    input wire logic s_axi_arvalid,
    output logic s_axi_arready,
    input wire logic [7:0] s_axi_araddr,
    input wire logic [2:0] s_axi_arprot,
    output logic s_axi_rvalid,
    input wire logic s_axi_rready,
    output logic [31:0] s_axi_rdata,
    output logic [1:0] s_axi_rresp,
    input wire logic supply_uv,
    input wire logic avdd_uv,
    input wire logic regulator_uv,
    input wire logic pump_undervoltage,
    input wire logic ov_above_20v,
    input wire logic ov_above_32v,
    input wire logic ov_above_34v,
    input wire logic overcurrent_raw,
    input wire logic regulator_oc,
    input wire logic serial_error,
    input wire logic trim_read_error,
    input wire logic current_limit_trip,
    input wire logic pwm_in,
    input wire logic sleep_pin_n,
    input wire logic pin_configured,
    output logic fault_out_n,
    output logic bridge_hiz,
    output logic pump_enable,
    output logic logic_enable,
    output logic regulator_enable,
    output logic high_side_enable,
    output logic overcurrent_level
);

    mdfm_state_t q;
    mdfm_state_t n;

    // ==========================================================
    // Decoders
    function automatic logic [1:0] reg_sel(input logic [7:0] a);
        if (a == `MDFM_CTRL_OFS) begin
            return 2'h0;
        end else if (a == `MDFM_STAT_OFS) begin
            return 2'h1;
        end
        return 2'h3;
    endfunction

    function automatic logic [7:0] deg_cyc(input logic hw, input logic [1:0] code);
        if (hw) begin
            return 8'(`MDFM_NS2CYC(`MDFM_DEG_HW_NS));
        end
        case (code)
            2'h0: return 8'(`MDFM_NS2CYC(`MDFM_DEG0_NS));
            2'h1: return 8'(`MDFM_NS2CYC(`MDFM_DEG1_NS));
            2'h2: return 8'(`MDFM_NS2CYC(`MDFM_DEG2_NS));
            default: return 8'(`MDFM_NS2CYC(`MDFM_DEG3_NS));
        endcase
    endfunction

    // ==========================================================
    // Next state
    always_comb begin
        logic hw;
        logic uv;
        logic ov_on;
        logic clr;
        logic sleep_clr;
        logic oc_det;
        logic oc_fault;
        logic tick;
        logic hiz_d;
        logic [7:0] deg;
        logic [11:0] period;
        logic [31:0] status;
        mdfm_oc_mode_t mode;
        n = q;
        hw = q.s2[`MDFM_I_PINCFG];
        uv = q.s2[`MDFM_I_SUP_UV] | q.s2[`MDFM_I_AV_UV];
        sleep_clr = 1'b0;
        oc_det = 1'b0;
        tick = 1'b0;
        n.s1 = {pin_configured, sleep_pin_n, pwm_in, current_limit_trip, trim_read_error,
            serial_error, regulator_oc, overcurrent_raw, ov_above_34v, ov_above_32v,
            ov_above_20v, pump_undervoltage, regulator_uv, avdd_uv, supply_uv};
        n.s2 = q.s1;
        n.pwm_prev = q.s2[`MDFM_I_PWM];
        n.sleep_prev = q.s2[`MDFM_I_SLEEP_N];
        n.ctrl[`MDFM_C_CLR] = 1'b0;

        // Sleep pin: short low pulse clears, long low shuts down
        if (!q.s2[`MDFM_I_SLEEP_N]) begin
            if (q.rst_cnt != 16'hFFFF) begin
                n.rst_cnt = q.rst_cnt + 16'h0001;
            end
            if (32'(q.rst_cnt) >= RST_MAX_CYC) begin
                n.asleep = 1'b1;
            end
        end else begin
            n.rst_cnt = 16'h0000;
            n.asleep = 1'b0;
            if (!q.sleep_prev && !q.asleep) begin
                sleep_clr = 1'b1;
            end
        end
        clr = q.ctrl[`MDFM_C_CLR] | sleep_clr;

        // Overvoltage source and threshold
        if (hw) begin
            ov_on = q.s2[`MDFM_I_OV34];
        end else if (q.ctrl[`MDFM_C_OV_EN]) begin
            ov_on = q.ctrl[`MDFM_C_OV_SEL] ? q.s2[`MDFM_I_OV32] : q.s2[`MDFM_I_OV20];
        end else begin
            ov_on = 1'b0;
        end

        // Overcurrent deglitch; pin parts always latch
        mode = hw ? MDFM_OC_LATCH : mdfm_oc_mode_t'(q.ctrl[`MDFM_C_OC_MODE]);
        deg = deg_cyc(hw, q.ctrl[`MDFM_C_OC_DEG]);
        if (!q.s2[`MDFM_I_OC]) begin
            n.deg_cnt = 8'h00;
        end else if (q.deg_cnt < deg) begin
            n.deg_cnt = q.deg_cnt + 8'h01;
        end else begin
            oc_det = 1'b1;
        end
        case (mode)
            MDFM_OC_LATCH: begin
                if (oc_det) begin
                    n.oc_hold = 1'b1;
                end else if (clr) begin
                    n.oc_hold = 1'b0;
                end
            end
            MDFM_OC_RETRY: begin
                n.oc_hold = 1'b0;
                if (q.oc_retry) begin
                    n.retry_cnt = q.retry_cnt + 24'h000001;
                    if (32'(q.retry_cnt) >= RETRY_CYC - 1) begin
                        n.oc_retry = 1'b0;
                    end
                end else if (oc_det) begin
                    n.oc_retry = 1'b1;
                    n.retry_cnt = 24'h000000;
                end
            end
            MDFM_OC_REPORT: begin
                n.oc_hold = 1'b0;
                n.oc_retry = 1'b0;
            end
            default: begin
                n.oc_hold = 1'b0;
                n.oc_retry = 1'b0;
                oc_det = 1'b0;
            end
        endcase
        oc_fault = q.oc_hold | q.oc_retry | (q.ocf & (mode == MDFM_OC_REPORT));

        // Regulator overcurrent retry, bridge untouched
        if (q.roc_retry) begin
            n.rretry_cnt = q.rretry_cnt + 24'h000001;
            if (32'(q.rretry_cnt) >= REG_RETRY_CYC - 1) begin
                n.roc_retry = 1'b0;
            end
        end else if (q.s2[`MDFM_I_REG_OC]) begin
            n.roc_retry = 1'b1;
            n.rretry_cnt = 24'h000000;
        end

        // Sticky flags: a present condition always wins over a clear
        n.por = uv ? 1'b0 : (q.por | clr);
        n.ruv = q.s2[`MDFM_I_REG_UV] | (q.ruv & ~clr);
        n.rflt = q.s2[`MDFM_I_REG_UV] | q.s2[`MDFM_I_REG_OC] | (q.rflt & ~clr);
        n.puv = q.s2[`MDFM_I_PMP_UV] | (q.puv & ~clr);
        n.ovf = ov_on | (q.ovf & ~clr);
        n.ocf = oc_det | (q.ocf & ~(clr & ~q.s2[`MDFM_I_OC]));
        n.roc = q.s2[`MDFM_I_REG_OC] | (q.roc & ~clr);
        n.serr = q.s2[`MDFM_I_SER] | (q.serr & ~clr);
        n.otp = q.s2[`MDFM_I_OTP] | (q.otp & ~sleep_clr);
        n.gflt = q.s2[`MDFM_I_REG_UV] | q.s2[`MDFM_I_PMP_UV] | ov_on | oc_det
            | q.s2[`MDFM_I_REG_OC] | (q.s2[`MDFM_I_SER] & ~q.ctrl[`MDFM_C_SER_DIS])
            | q.s2[`MDFM_I_OTP] | (q.gflt & ~clr);

        // Pin drives
        hiz_d = uv | q.s2[`MDFM_I_PMP_UV] | ov_on | q.oc_hold | q.oc_retry
            | q.otp | q.asleep;
        n.hiz = hiz_d;
        n.pump_en = ~(uv | q.asleep);
        n.logic_en = ~(uv | q.asleep);
        n.reg_en = ~(q.s2[`MDFM_I_REG_UV] | q.roc_retry | q.asleep);
        // Logic is off under supply undervoltage, so the fault pin is released
        n.fault_n = uv | q.asleep | ~(q.s2[`MDFM_I_REG_UV] | q.s2[`MDFM_I_PMP_UV] | ov_on
            | oc_fault | q.roc_retry | (q.serr & ~q.ctrl[`MDFM_C_SER_DIS])
            | q.otp);

        // Restart clock for the full-duty case
        period = (!hw && q.ctrl[`MDFM_C_PWM_SEL]) ? 12'(`MDFM_RS_FAST_CYC)
            : 12'(`MDFM_RS_SLOW_CYC);
        if (q.rs_cnt >= period - 12'h001) begin
            n.rs_cnt = 12'h000;
            tick = 1'b1;
        end else begin
            n.rs_cnt = q.rs_cnt + 12'h001;
        end
        if (!q.s2[`MDFM_I_PWM]) begin
            n.hs_off = 1'b0;
        end else if (q.s2[`MDFM_I_ILIM]) begin
            n.hs_off = 1'b1;
        end else if (!q.pwm_prev || tick) begin
            n.hs_off = 1'b0;
        end
        n.hs_en = q.s2[`MDFM_I_PWM] & ~n.hs_off & ~hiz_d;

        // AXI4-Lite write
        if (s_axi_awvalid && q.awready) begin
            n.aw_have = 1'b1;
            n.awaddr = s_axi_awaddr;
        end
        if (s_axi_wvalid && q.wready) begin
            n.w_have = 1'b1;
            n.wdata = s_axi_wdata;
            n.wstrb = s_axi_wstrb;
        end
        if (q.bvalid && s_axi_bready) begin
            n.bvalid = 1'b0;
        end
        if (q.aw_have && q.w_have && !q.bvalid) begin
            n.aw_have = 1'b0;
            n.w_have = 1'b0;
            n.bvalid = 1'b1;
            n.bresp = 2'h0;
            case (reg_sel(q.awaddr))
                2'h0: begin
                    if (q.wstrb[0]) begin
                        n.ctrl[7:0] = q.wdata[7:0];
                    end
                    if (q.wstrb[1]) begin
                        n.ctrl[9:8] = q.wdata[9:8];
                    end
                end
                2'h1: n.bresp = 2'h0;
                default: n.bresp = 2'h2;
            endcase
        end
        n.awready = ~n.aw_have & ~n.bvalid;
        n.wready = ~n.w_have & ~n.bvalid;

        // AXI4-Lite read
        status = {20'h00000, q.hiz, q.fault_n, q.otp, q.serr, q.roc, q.ocf,
            q.ovf, q.puv, q.ruv, q.rflt, q.gflt, q.por};
        if (q.rvalid && s_axi_rready) begin
            n.rvalid = 1'b0;
        end
        if (s_axi_arvalid && q.arready) begin
            n.rvalid = 1'b1;
            n.rresp = 2'h0;
            case (reg_sel(s_axi_araddr))
                2'h0: n.rdata = {22'h000000, q.ctrl[9:1], 1'b0};
                2'h1: n.rdata = status;
                default: begin
                    n.rdata = 32'h00000000;
                    n.rresp = 2'h2;
                end
            endcase
        end
        n.arready = ~n.rvalid;
    end

    // ==========================================================
    // State register
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            q <= '0;
            q.ctrl <= `MDFM_CTRL_RST;
            q.fault_n <= 1'b1;
            q.hiz <= 1'b1;
            q.sleep_prev <= 1'b1;
            q.s1[`MDFM_I_SLEEP_N] <= 1'b1;
            q.s2[`MDFM_I_SLEEP_N] <= 1'b1;
        end else begin
            q <= n;
        end
    end

    assign s_axi_awready = q.awready;
    assign s_axi_wready = q.wready;
    assign s_axi_bvalid = q.bvalid;
    assign s_axi_bresp = q.bresp;
    assign s_axi_arready = q.arready;
    assign s_axi_rvalid = q.rvalid;
    assign s_axi_rdata = q.rdata;
    assign s_axi_rresp = q.rresp;
    assign fault_out_n = q.fault_n;
    assign bridge_hiz = q.hiz;
    assign pump_enable = q.pump_en;
    assign logic_enable = q.logic_en;
    assign regulator_enable = q.reg_en;
    assign high_side_enable = q.hs_en;
    assign overcurrent_level = q.ctrl[`MDFM_C_OC_LVL];

endmodule // mdfm_fault_mgr
`default_nettype wire

// *** common/mdfm_map.svh ***
// Offsets, field positions, reset values and timing counts of the fault manager
`ifndef MDFM_MAP_SVH
`define MDFM_MAP_SVH
// ==========================================================
// Register offsets (byte addresses)
`define MDFM_CTRL_OFS 8'h00
`define MDFM_STAT_OFS 8'h04
// ==========================================================
// Control fields
`define MDFM_C_CLR 0
`define MDFM_C_OV_EN 1
`define MDFM_C_OV_SEL 2
`define MDFM_C_OC_MODE 4:3
`define MDFM_C_OC_DEG 6:5
`define MDFM_C_OC_LVL 7
`define MDFM_C_PWM_SEL 8
`define MDFM_C_SER_DIS 9
`define MDFM_CTRL_RST 10'h000
// ==========================================================
// Synchronised input bit positions
`define MDFM_I_SUP_UV 0
`define MDFM_I_AV_UV 1
`define MDFM_I_REG_UV 2
`define MDFM_I_PMP_UV 3
`define MDFM_I_OV20 4
`define MDFM_I_OV32 5
`define MDFM_I_OV34 6
`define MDFM_I_OC 7
`define MDFM_I_REG_OC 8
`define MDFM_I_SER 9
`define MDFM_I_OTP 10
`define MDFM_I_ILIM 11
`define MDFM_I_PWM 12
`define MDFM_I_SLEEP_N 13
`define MDFM_I_PINCFG 14
// ==========================================================
// Timing
`define MDFM_CLK_KHZ 40000
`define MDFM_RS_SLOW_KHZ 20
`define MDFM_RS_FAST_KHZ 40
`define MDFM_RS_SLOW_CYC (`MDFM_CLK_KHZ / `MDFM_RS_SLOW_KHZ)
`define MDFM_RS_FAST_CYC (`MDFM_CLK_KHZ / `MDFM_RS_FAST_KHZ)
`define MDFM_DEG_HW_NS 600
`define MDFM_DEG0_NS 200
`define MDFM_DEG1_NS 600
`define MDFM_DEG2_NS 1200
`define MDFM_DEG3_NS 1600
`define MDFM_NS2CYC(ns) (((ns) * (`MDFM_CLK_KHZ / 1000) + 999) / 1000)
`define MDFM_RETRY_US 500
`define MDFM_REG_RETRY_US 500
`define MDFM_RETRY_CYC (`MDFM_RETRY_US * (`MDFM_CLK_KHZ / 1000))
`define MDFM_REG_RETRY_CYC (`MDFM_REG_RETRY_US * (`MDFM_CLK_KHZ / 1000))
`define MDFM_RST_MAX_US 40
`define MDFM_RST_MAX_CYC (`MDFM_RST_MAX_US * (`MDFM_CLK_KHZ / 1000))
`endif

// *** common/mdfm_pkg.sv ***
// Types of the motor driver fault manager
package mdfm_pkg;
    typedef enum logic [1:0] {
        MDFM_OC_LATCH = 2'b00,
        MDFM_OC_RETRY = 2'b01,
        MDFM_OC_REPORT = 2'b10,
        MDFM_OC_NONE = 2'b11
    } mdfm_oc_mode_t;

    typedef struct packed {
        logic [14:0] s1;
        logic [14:0] s2;
        logic pwm_prev;
        logic sleep_prev;
        logic [9:0] ctrl;
        logic por;
        logic gflt;
        logic rflt;
        logic ruv;
        logic puv;
        logic ovf;
        logic ocf;
        logic roc;
        logic serr;
        logic otp;
        logic oc_hold;
        logic oc_retry;
        logic roc_retry;
        logic [7:0] deg_cnt;
        logic [23:0] retry_cnt;
        logic [23:0] rretry_cnt;
        logic [15:0] rst_cnt;
        logic asleep;
        logic [11:0] rs_cnt;
        logic hs_off;
        logic fault_n;
        logic hiz;
        logic pump_en;
        logic logic_en;
        logic reg_en;
        logic hs_en;
        logic awready;
        logic wready;
        logic aw_have;
        logic w_have;
        logic [7:0] awaddr;
        logic [31:0] wdata;
        logic [3:0] wstrb;
        logic bvalid;
        logic [1:0] bresp;
        logic arready;
        logic rvalid;
        logic [31:0] rdata;
        logic [1:0] rresp;
    } mdfm_state_t;
endpackage

// *** test/mdfm_fault_mgr_monitor.sv ***
// Concurrent checks on the fault manager ports
`timescale 1ns/1ps
`default_nettype none
module mdfm_fault_mgr_monitor #(
    parameter int unsigned RST_MAX_CYC = 1600
) (
    input wire logic aclk,
    input wire logic aresetn,
    input wire logic supply_uv,
    input wire logic avdd_uv,
    input wire logic regulator_uv,
    input wire logic pump_undervoltage,
    input wire logic ov_above_34v,
    input wire logic overcurrent_raw,
    input wire logic regulator_oc,
    input wire logic trim_read_error,
    input wire logic current_limit_trip,
    input wire logic pwm_in,
    input wire logic sleep_pin_n,
    input wire logic pin_configured,
    input wire logic fault_out_n,
    input wire logic bridge_hiz,
    input wire logic pump_enable,
    input wire logic logic_enable,
    input wire logic regulator_enable,
    input wire logic high_side_enable
);
    // ==========================================================
    // Helper counters
    logic ok;
    logic [15:0] low_q;
    logic [7:0] oc_q;
    logic [11:0] hs_q;
    // Logic is off under supply faults or sleep, so the fault pin means nothing there
    assign ok = sleep_pin_n && !supply_uv && !avdd_uv;
    always_ff @(posedge aclk) begin
        if (!aresetn || sleep_pin_n) begin
            low_q <= 16'h0000;
        end else if (low_q != 16'hFFFF) begin
            low_q <= low_q + 16'h0001;
        end
        if (!aresetn || !(ok && pin_configured && overcurrent_raw)) begin
            oc_q <= 8'h00;
        end else if (oc_q != 8'hFF) begin
            oc_q <= oc_q + 8'h01;
        end
        if (!aresetn || high_side_enable || !pwm_in || !ok || current_limit_trip || bridge_hiz) begin
            hs_q <= 12'h000;
        end else if (hs_q != 12'hFFF) begin
            hs_q <= hs_q + 12'h001;
        end
    end
    default clocking dcb @(posedge aclk);
    endclocking
    default disable iff (!aresetn);
    // ==========================================================
    // Assertions
    AST_SUPPLY_UV: assert property (supply_uv [*4]
        |-> bridge_hiz && !pump_enable && !logic_enable) else $error("supply uv outputs on");
    AST_AVDD_UV: assert property (avdd_uv [*4]
        |-> bridge_hiz && !pump_enable && !logic_enable) else $error("avdd uv outputs on");
    AST_REG_UV: assert property ((ok && regulator_uv) [*4]
        |-> !regulator_enable && !fault_out_n) else $error("regulator uv not handled");
    AST_PUMP_UV: assert property ((ok && pump_undervoltage) [*4]
        |-> bridge_hiz && !fault_out_n) else $error("pump uv not handled");
    AST_OV_PIN: assert property ((ok && pin_configured && ov_above_34v) [*4]
        |-> bridge_hiz && !fault_out_n) else $error("pin part overvoltage not handled");
    AST_TRIM: assert property ((ok && trim_read_error) [*5]
        |-> bridge_hiz && !fault_out_n) else $error("trim error not handled");
    AST_REG_OC: assert property ((ok && !regulator_oc) ##1 (ok && regulator_oc) [*5]
        |-> !fault_out_n) else $error("regulator overcurrent not reported");
    AST_OC_PIN: assert property (oc_q == 8'd30
        |-> !fault_out_n && bridge_hiz) else $error("pin part overcurrent not latched");
    AST_RESTART: assert property (hs_q != 12'd2015) else $error("high side not restarted");
    AST_SLEEP: assert property (low_q == 16'(RST_MAX_CYC + 8)
        |-> bridge_hiz && fault_out_n && !pump_enable) else $error("long sleep low ignored");
endmodule // mdfm_fault_mgr_monitor

bind mdfm_fault_mgr mdfm_fault_mgr_monitor #(.RST_MAX_CYC(RST_MAX_CYC)) u_mdfm_fault_mgr_monitor (
    .aclk, .aresetn, .supply_uv, .avdd_uv, .regulator_uv, .pump_undervoltage, .ov_above_34v,
    .overcurrent_raw, .regulator_oc, .trim_read_error, .current_limit_trip, .pwm_in,
    .sleep_pin_n, .pin_configured, .fault_out_n, .bridge_hiz, .pump_enable, .logic_enable,
    .regulator_enable, .high_side_enable
);
`default_nettype wire

// *** test/mdfm_mcu_model.sv ***
// Controller model: PWM drive and sleep-pin reset pulses
`timescale 1ns/1ps
`default_nettype none
module mdfm_mcu_model #(
    parameter int unsigned LOW_CYC = 4
) (
    input wire logic aclk,
    input wire logic full_duty,
    input wire logic rst_req,
    input wire logic sleep_req,
    output var logic pwm_in,
    output var logic sleep_pin_n
);
    // ==========================================================
    // Short low keeps inside the reset window; a long low means sleep
    int unsigned cnt = 0;
    always @(posedge aclk) begin
        pwm_in <= full_duty;
        if (rst_req && cnt == 0) begin
            cnt <= LOW_CYC;
        end else if (cnt != 0) begin
            cnt <= cnt - 1;
        end
        sleep_pin_n <= !(sleep_req || (rst_req && cnt == 0) || cnt > 1);
    end
endmodule // mdfm_mcu_model
`default_nettype wire

// *** test/mdfm_fault_mgr_tb.sv ***
// Directed bench for the fault manager
`timescale 1ns/1ps
`default_nettype none
module mdfm_fault_mgr_tb;
    localparam int RTY = 20;
    logic aclk = 1'b0;
    logic aresetn = 1'b0;
    logic awv = 1'b0;
    logic wv = 1'b0;
    logic br = 1'b0;
    logic arv = 1'b0;
    logic rr = 1'b0;
    logic pin = 1'b0;
    logic full = 1'b0;
    logic rq = 1'b0;
    logic slq = 1'b0;
    logic [7:0] aw = 8'h00;
    logic [7:0] ar = 8'h00;
    logic [31:0] wd = 32'h0;
    logic [11:0] flt = 12'h000;
    logic awr, wr, bv, arr, rv, pwm, slp, fo, hz, pe, le, re, he, ol;
    logic [1:0] bp, rp;
    logic [31:0] rdat, d, ctl;
    int n;
    int err_count = 0;
    int comparisons = 0;
    // Pin, enable, select, expected fault, comparator index
    logic [5:0] ovt [6] = '{6'h00, 6'h14, 6'h18, 6'h1D, 6'h26, 6'h21};
    logic [2:0] oce [4] = '{3'h3, 3'h3, 3'h1, 3'h5};
    logic [1:0] oca [4] = '{2'h1, 2'h2, 2'h0, 2'h2};

    always #12.5 aclk = ~aclk;

    mdfm_fault_mgr #(.RETRY_CYC(RTY), .REG_RETRY_CYC(RTY), .RST_MAX_CYC(10)) u_mdfm_fault_mgr (
        .aclk(aclk), .aresetn(aresetn), .s_axi_awvalid(awv), .s_axi_awready(awr),
        .s_axi_awaddr(aw), .s_axi_awprot(3'h0), .s_axi_wvalid(wv), .s_axi_wready(wr),
        .s_axi_wdata(wd), .s_axi_wstrb(4'hF), .s_axi_bvalid(bv), .s_axi_bready(br),
        .s_axi_bresp(bp), .s_axi_arvalid(arv), .s_axi_arready(arr), .s_axi_araddr(ar),
        .s_axi_arprot(3'h0), .s_axi_rvalid(rv), .s_axi_rready(rr), .s_axi_rdata(rdat),
        .s_axi_rresp(rp), .supply_uv(flt[0]), .avdd_uv(flt[1]), .regulator_uv(flt[2]),
        .pump_undervoltage(flt[3]), .ov_above_20v(flt[4]), .ov_above_32v(flt[5]),
        .ov_above_34v(flt[6]), .overcurrent_raw(flt[7]), .regulator_oc(flt[8]),
        .serial_error(flt[9]), .trim_read_error(flt[10]), .current_limit_trip(flt[11]),
        .pwm_in(pwm), .sleep_pin_n(slp), .pin_configured(pin), .fault_out_n(fo),
        .bridge_hiz(hz), .pump_enable(pe), .logic_enable(le), .regulator_enable(re),
        .high_side_enable(he), .overcurrent_level(ol));
    mdfm_mcu_model #(.LOW_CYC(4)) u_mdfm_mcu_model (.aclk(aclk), .full_duty(full),
        .rst_req(rq), .sleep_req(slq), .pwm_in(pwm), .sleep_pin_n(slp));

    // ==========================================================
    // Tasks
    task automatic chk(input logic [31:0] g, input logic [31:0] e);
        comparisons++;
        if (g !== e) begin
            err_count++;
            $display("[ERR] t=%0t got=%h exp=%h", $time, g, e);
        end
    endtask
    task automatic cyc(input int c);
        repeat (c) @(posedge aclk);
    endtask
    task automatic wrt(input logic [7:0] a, input logic [31:0] v, input logic [1:0] e);
        logic ta;
        logic tw;
        ta = 1'b0;
        tw = 1'b0;
        aw <= a;
        wd <= v;
        awv <= 1'b1;
        wv <= 1'b1;
        br <= 1'b1;
        while (!(ta && tw)) begin
            @(posedge aclk);
            if (awv && awr) begin
                ta = 1'b1;
                awv <= 1'b0;
            end
            if (wv && wr) begin
                tw = 1'b1;
                wv <= 1'b0;
            end
        end
        do @(posedge aclk); while (!bv);
        chk(bp, e);
        br <= 1'b0;
        @(posedge aclk);
    endtask
    task automatic rdt(input logic [7:0] a, output logic [31:0] v, input logic [1:0] e);
        ar <= a;
        arv <= 1'b1;
        rr <= 1'b1;
        do @(posedge aclk); while (!arr);
        arv <= 1'b0;
        do @(posedge aclk); while (!rv);
        v = rdat;
        chk(rp, e);
        rr <= 1'b0;
        @(posedge aclk);
    endtask
    task automatic setc(input logic [31:0] v);
        ctl = v;
        wrt(8'h00, v, 2'h0);
    endtask
    task automatic clr;
        wrt(8'h00, ctl | 32'h1, 2'h0);
        cyc(2);
    endtask
    task automatic ev(input int i, input int c, input logic [2:0] e);
        flt[i] <= 1'b1;
        cyc(c);
        chk({fo, hz, pe}, e);
    endtask
    task automatic off(input int i);
        flt[i] <= 1'b0;
        cyc(8);
    endtask
    task automatic report_and_stop;
        $display("comparisons=%0d errors=%0d", comparisons, err_count);
        if (err_count == 0 && comparisons > 0) begin
            $display("All tests passed");
        end else begin
            $display("Some tests failed");
        end
        $finish;
    endtask

    // ==========================================================
    // Sequence
    initial begin
        cyc(10);
        aresetn <= 1'b1;
        cyc(4);
        rdt(8'h00, d, 2'h0);
        chk(d, 32'h0);
        rdt(8'h04, d, 2'h0);
        chk(d[0], 1'b0);
        wrt(8'h08, 32'h1, 2'h2);
        rdt(8'h0C, d, 2'h2);
        chk(d, 32'h0);
        wrt(8'h04, 32'hFFF, 2'h0);
        setc(32'h3FF);
        rdt(8'h00, d, 2'h0);
        chk(d, 32'h3FE);
        chk(ol, 1'b1);
        rdt(8'h04, d, 2'h0);
        chk(d[0], 1'b1);
        setc(32'h0);
        for (int k = 0; k < 2; k++) begin
            ev(k, 10, 3'h6);
            chk(le, 1'b0);
            off(k);
            chk({fo, hz, pe}, 3'h5);
            rdt(8'h04, d, 2'h0);
            chk(d[0], 1'b0);
            clr();
            rdt(8'h04, d, 2'h0);
            chk(d[0], 1'b1);
        end
        ev(2, 10, 3'h1);
        chk(re, 1'b0);
        off(2);
        chk({fo, re}, 2'h3);
        rdt(8'h04, d, 2'h0);
        chk(d[3:1], 3'h7);
        clr();
        rdt(8'h04, d, 2'h0);
        chk(d[3:1], 3'h0);
        ev(3, 10, 3'h3);
        clr();
        rdt(8'h04, d, 2'h0);
        chk(d[4], 1'b1);
        off(3);
        chk({fo, hz}, 2'h2);
        clr();
        foreach (ovt[j]) begin
            pin <= ovt[j][5];
            setc({29'h0, ovt[j][3], ovt[j][4], 1'b0});
            ev(4 + ovt[j][1:0], 10, {!ovt[j][2], ovt[j][2], 1'b1});
            off(4 + ovt[j][1:0]);
            rdt(8'h04, d, 2'h0);
            chk(d[5], ovt[j][2]);
            clr();
        end
        pin <= 1'b0;
        setc(32'h0);
        ev(7, 4, 3'h5);
        off(7);
        chk(fo, 1'b1);
        for (int m = 0; m < 4; m++) begin
            setc(32'(m) << 3);
            ev(7, 20, oce[m]);
            off(7);
            cyc(RTY + 10);
            chk({fo, hz}, oca[m]);
            rdt(8'h04, d, 2'h0);
            chk(d[6], m != 3);
            clr();
            chk({fo, hz}, 2'h2);
        end
        pin <= 1'b1;
        setc(32'h18);
        ev(7, 40, 3'h3);
        off(7);
        chk({fo, hz}, 2'h1);
        clr();
        pin <= 1'b0;
        setc(32'h0);
        ev(8, 8, 3'h1);
        off(8);
        cyc(RTY + 10);
        chk(fo, 1'b1);
        rdt(8'h04, d, 2'h0);
        chk(d[7], 1'b1);
        clr();
        for (int k = 0; k < 2; k++) begin
            setc(32'(k) << 9);
            ev(9, 6, {k[0], 2'h1});
            off(9);
            rdt(8'h04, d, 2'h0);
            chk(d[8], 1'b1);
            clr();
            chk(fo, 1'b1);
        end
        ev(10, 6, 3'h3);
        off(10);
        clr();
        rdt(8'h04, d, 2'h0);
        chk(d[9], 1'b1);
        rq <= 1'b1;
        cyc(1);
        rq <= 1'b0;
        cyc(12);
        rdt(8'h04, d, 2'h0);
        chk({d[9], fo}, 2'h1);
        full <= 1'b1;
        cyc(6);
        chk(he, 1'b1);
        for (int k = 0; k < 2; k++) begin
            setc(32'(k) << 8);
            flt[11] <= 1'b1;
            cyc(4);
            flt[11] <= 1'b0;
            chk(he, 1'b0);
            for (n = 0; !he && n < 2100; n++) begin
                cyc(1);
            end
            chk(32'(n < (k ? 1010 : 2010)), 1);
        end
        slq <= 1'b1;
        cyc(30);
        chk({fo, hz, pe}, 3'h6);
        slq <= 1'b0;
        cyc(10);
        chk(hz, 1'b0);
        report_and_stop();
    end

    // Whole sequence needs about 3000 cycles
    initial begin
        cyc(20000);
        err_count++;
        report_and_stop();
    end
endmodule // mdfm_fault_mgr_tb
`default_nettype wire
